// ===== rtcac_map.vh
// Address map, field positions and reset values of the dual alarm compare block.
// Assumes byte-wide registers reached through a 5-bit register address.
`ifndef RTCAC_MAP_VH
`define RTCAC_MAP_VH

// Register addresses
`define RTCAC_ADDR_STATUS 5'h07
`define RTCAC_ADDR_A1_FIRST 5'h0c
`define RTCAC_ADDR_A1_LAST 5'h11
`define RTCAC_ADDR_A2_FIRST 5'h12
`define RTCAC_ADDR_A2_LAST 5'h14

// Alarm byte slots, counted from the first alarm-1 byte
`define RTCAC_SLOT_A1_SEC 4'h0
`define RTCAC_SLOT_A1_MIN 4'h1
`define RTCAC_SLOT_A1_HOUR 4'h2
`define RTCAC_SLOT_A1_DATE 4'h3
`define RTCAC_SLOT_A1_MONTH 4'h4
`define RTCAC_SLOT_A1_WDAY 4'h5
`define RTCAC_SLOT_A2_MIN 4'h6
`define RTCAC_SLOT_A2_HOUR 4'h7
`define RTCAC_SLOT_A2_DAY 4'h8
`define RTCAC_SLOT_COUNT 9

// Field positions inside an alarm byte
`define RTCAC_BIT_COMPARE_ON 7
`define RTCAC_BIT_DAY_SELECT 6

// Field positions inside the status byte
`define RTCAC_BIT_FIRST_FLAG 2
`define RTCAC_BIT_SECOND_FLAG 1

// Reset values and constants
`define RTCAC_ALARM_RESET 8'h00
`define RTCAC_BYTE_ZERO 8'h00
`define RTCAC_SECONDS_ZERO 7'h00

`endif

// ===== rtcac_field_match.v
// Parallel compare of several alarm fields against clock fields.
// Assumes packed 7-bit values, one slice per field, and one enable per field.
`timescale 1ns/1ps
`default_nettype none

module rtcac_field_match #(
    parameter N = 6
) (
    // Compare enables, one per field
    input wire [N-1:0] i_field_on,
    // Alarm and clock values, 7 bits per field
    input wire [7*N-1:0] i_alarm_val,
    input wire [7*N-1:0] i_clock_val,
    // All enabled fields equal
    output wire o_match
);

    wire [N-1:0] field_ok;

    // A disabled field always passes
    genvar g;
    generate
        for (g = 0; g < N; g = g + 1) begin : g_field
            assign field_ok[g] = ~i_field_on[g] |
                (i_alarm_val[7*g +: 7] == i_clock_val[7*g +: 7]);
        end
    endgenerate

    assign o_match = &field_ok;

endmodule // rtcac_field_match
`default_nettype wire

// ===== rtcac_alarm.v
// Dual alarm compare block: alarm bytes, match logic, status flags, interrupt pin.
// Assumes an external serial slave turns bus traffic into byte register strobes,
// and the clock counters supply BCD time bytes plus a one-cycle update tick.
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_map.vh"

// What this block does
// [R1] Six first-alarm bytes; bit 7 enables compare, low bits hold BCD value.
// [R2] First alarm compares seconds to weekday only, no year byte.
// [R3] First alarm on with no field enabled fires every second.
// [R4] First alarm fires when all enabled fields equal the clock.
// [R5] First-alarm enables map seconds, minutes, hours, date, month, weekday.
// [R6] First-alarm match is judged at the clock update reaching target time.
// [R7] First alarm sets its flag and, if routed, pulls the pin low.
// [R8] Host clears the first flag by writing 0, or uses auto clear.
// [R9] Three second-alarm bytes: minutes, hours, shared date/weekday.
// [R10] Second alarm with no field enabled fires each minute at second 00.
// [R11] Bit 6 of the day byte picks weekday (1) or date (0).
// [R12] Second alarm fires when all enabled fields equal the clock.
// [R13] Second-alarm match sets the second flag to 1.
// [R14] Host clears the second flag by writing 0, or uses auto clear.
// [R15] Hour compare fails when 12/24-hour format bits differ.
// [R16] Auto clear wipes both flags after a status read ending in STOP.
// [R17] Pin pulls low only with route, pin select and alarm function on.
// [R18] Second alarm never drives the interrupt pin.
// [R19] Flags set once per matching update, not continuously.
module rtcac_alarm (
    // Clock and reset
    input wire I_SYS_CLK,
    input wire I_RESET,
    // Register strobes from the serial slave
    input wire I_REG_WR,
    input wire [4:0] I_REG_ADDR,
    input wire [7:0] I_REG_WDATA,
    input wire I_STATUS_READ_STOP,
    output reg [7:0] O_REG_RDATA,
    // Current time from the clock counters
    input wire I_TIME_TICK,
    input wire [7:0] I_SECONDS,
    input wire [7:0] I_MINUTES,
    input wire [7:0] I_HOURS,
    input wire [7:0] I_DATE,
    input wire [7:0] I_MONTH,
    input wire [7:0] I_WEEKDAY_COUNT,
    // Control bits held elsewhere
    input wire I_FIRST_ALARM_FUNCTION_ON,
    input wire I_SECOND_ALARM_FUNCTION_ON,
    input wire I_FIRST_ALARM_PIN_ROUTE,
    input wire I_OUTPUT_PIN_FUNCTION_SELECT,
    input wire I_ALARM_FLAG_AUTO_CLEAR,
    // Status flags
    output reg O_FIRST_ALARM_FLAG,
    output reg O_SECOND_ALARM_FLAG,
    // Open-drain interrupt pin
    output reg O_IRQ_OUT,
    output reg O_IRQ_OE_N
);

    reg [7:0] alarm_byte [0:`RTCAC_SLOT_COUNT-1];
    wire [3:0] slot;
    wire [4:0] slot_offset;
    wire hit_alarm;
    wire hit_status;
    wire [5:0] a1_on;
    wire [41:0] a1_val;
    wire [41:0] a1_clk;
    wire [2:0] a2_on;
    wire [20:0] a2_val;
    wire [20:0] a2_clk;
    wire [6:0] a2_day_clk;
    wire a1_match;
    wire a2_match;
    wire a1_fire;
    wire a2_fire;
    wire clear_first;
    wire clear_second;
    wire auto_clear;
    reg next_first_flag;
    reg next_second_flag;
    reg [7:0] next_rdata;
    integer k;

    // True when an address falls on one of the alarm bytes
    function in_alarm_range;
        input [4:0] addr;
        begin
            in_alarm_range = (addr >= `RTCAC_ADDR_A1_FIRST) &&
                (addr <= `RTCAC_ADDR_A2_LAST);
        end
    endfunction

    // Compare enable of one alarm byte
    function compare_on;
        input [7:0] abyte;
        begin
            compare_on = abyte[`RTCAC_BIT_COMPARE_ON];
        end
    endfunction

    // Address decode
    assign hit_alarm = in_alarm_range(I_REG_ADDR);
    assign hit_status = (I_REG_ADDR == `RTCAC_ADDR_STATUS);
    assign slot_offset = I_REG_ADDR - `RTCAC_ADDR_A1_FIRST;
    assign slot = hit_alarm ? slot_offset[3:0] : 4'h0; // Nine slots fit in 4 bits

    // [R1] alarm byte storage
    always @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            for (k = 0; k < `RTCAC_SLOT_COUNT; k = k + 1) begin
                alarm_byte[k] <= `RTCAC_ALARM_RESET;
            end
        end else if (I_REG_WR && hit_alarm) begin
            alarm_byte[slot] <= I_REG_WDATA;
        end
    end

    // [R5] enables in field order
    assign a1_on = {compare_on(alarm_byte[`RTCAC_SLOT_A1_WDAY]),
                    compare_on(alarm_byte[`RTCAC_SLOT_A1_MONTH]),
                    compare_on(alarm_byte[`RTCAC_SLOT_A1_DATE]),
                    compare_on(alarm_byte[`RTCAC_SLOT_A1_HOUR]),
                    compare_on(alarm_byte[`RTCAC_SLOT_A1_MIN]),
                    compare_on(alarm_byte[`RTCAC_SLOT_A1_SEC])};

    // [R2] six fields only, hour keeps its format bit
    assign a1_val = {alarm_byte[`RTCAC_SLOT_A1_WDAY][6:0],
                     alarm_byte[`RTCAC_SLOT_A1_MONTH][6:0],
                     alarm_byte[`RTCAC_SLOT_A1_DATE][6:0],
                     alarm_byte[`RTCAC_SLOT_A1_HOUR][6:0],
                     alarm_byte[`RTCAC_SLOT_A1_MIN][6:0],
                     alarm_byte[`RTCAC_SLOT_A1_SEC][6:0]};
    assign a1_clk = {I_WEEKDAY_COUNT[6:0], I_MONTH[6:0], I_DATE[6:0],
                     I_HOURS[6:0], I_MINUTES[6:0], I_SECONDS[6:0]};

    // [R4] first alarm field compare
    rtcac_field_match #(
        .N(6)
    ) u_a1_match (
        .i_field_on(a1_on),
        .i_alarm_val(a1_val),
        .i_clock_val(a1_clk),
        .o_match(a1_match)
    );

    // [R11] day byte compares weekday or date
    assign a2_day_clk = alarm_byte[`RTCAC_SLOT_A2_DAY][`RTCAC_BIT_DAY_SELECT] ?
        {4'h0, I_WEEKDAY_COUNT[2:0]} : {1'b0, I_DATE[5:0]};

    // [R9] three second-alarm fields
    assign a2_on = {compare_on(alarm_byte[`RTCAC_SLOT_A2_DAY]),
                    compare_on(alarm_byte[`RTCAC_SLOT_A2_HOUR]),
                    compare_on(alarm_byte[`RTCAC_SLOT_A2_MIN])};
    assign a2_val = {1'b0, alarm_byte[`RTCAC_SLOT_A2_DAY][5:0],
                     alarm_byte[`RTCAC_SLOT_A2_HOUR][6:0],
                     alarm_byte[`RTCAC_SLOT_A2_MIN][6:0]};
    // [R15] hour slice carries the 24-hour format bit
    assign a2_clk = {a2_day_clk, I_HOURS[6:0], I_MINUTES[6:0]};

    // [R12] second alarm field compare
    rtcac_field_match #(
        .N(3)
    ) u_a2_match (
        .i_field_on(a2_on),
        .i_alarm_val(a2_val),
        .i_clock_val(a2_clk),
        .o_match(a2_match)
    );

    // [R3] [R6] judged once per clock update
    assign a1_fire = I_TIME_TICK && I_FIRST_ALARM_FUNCTION_ON && a1_match;

    // [R10] only at second 00
    assign a2_fire = I_TIME_TICK && I_SECOND_ALARM_FUNCTION_ON && a2_match &&
        (I_SECONDS[6:0] == `RTCAC_SECONDS_ZERO);

    // [R8] [R14] write of 0 clears a flag
    assign clear_first = I_REG_WR && hit_status &&
        !I_REG_WDATA[`RTCAC_BIT_FIRST_FLAG];
    assign clear_second = I_REG_WR && hit_status &&
        !I_REG_WDATA[`RTCAC_BIT_SECOND_FLAG];

    // [R16] status read closed by STOP
    assign auto_clear = I_ALARM_FLAG_AUTO_CLEAR && I_STATUS_READ_STOP;

    // Flag next state, set beats clear
    always @* begin
        next_first_flag = O_FIRST_ALARM_FLAG;
        next_second_flag = O_SECOND_ALARM_FLAG;
        if (clear_first || auto_clear) begin
            next_first_flag = 1'b0;
        end
        if (clear_second || auto_clear) begin
            next_second_flag = 1'b0;
        end
        // [R19] set only on a matching update
        if (a1_fire) begin
            next_first_flag = 1'b1;
        end
        if (a2_fire) begin
            next_second_flag = 1'b1;
        end
    end

    // [R7] [R13] flag registers
    always @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_FIRST_ALARM_FLAG <= 1'b0;
            O_SECOND_ALARM_FLAG <= 1'b0;
        end else begin
            O_FIRST_ALARM_FLAG <= next_first_flag;
            O_SECOND_ALARM_FLAG <= next_second_flag;
        end
    end

    // [R17] [R18] pin follows first flag only
    always @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_IRQ_OUT <= 1'b0;
            O_IRQ_OE_N <= 1'b1;
        end else begin
            O_IRQ_OUT <= 1'b0;
            O_IRQ_OE_N <= ~(next_first_flag && I_FIRST_ALARM_PIN_ROUTE &&
                I_OUTPUT_PIN_FUNCTION_SELECT && I_FIRST_ALARM_FUNCTION_ON);
        end
    end

    // Read data selection
    always @* begin
        next_rdata = `RTCAC_BYTE_ZERO;
        if (hit_alarm) begin
            next_rdata = alarm_byte[slot];
        end else if (hit_status) begin
            next_rdata[`RTCAC_BIT_FIRST_FLAG] = O_FIRST_ALARM_FLAG;
            next_rdata[`RTCAC_BIT_SECOND_FLAG] = O_SECOND_ALARM_FLAG;
        end
    end

    // Registered read data
    always @(posedge I_SYS_CLK) begin
        if (I_RESET) begin
            O_REG_RDATA <= `RTCAC_BYTE_ZERO;
        end else begin
            O_REG_RDATA <= next_rdata;
        end
    end

endmodule // rtcac_alarm
`default_nettype wire

// ===== rtcac_alarm_asserts.sv
// Checker for the dual alarm compare block.
// Sees only top module ports; bound from the testbench.
`timescale 1ns/1ps
`default_nettype none
module rtcac_alarm_asserts (
    // Watched ports
    input wire I_SYS_CLK,
    input wire I_RESET,
    input wire I_REG_WR,
    input wire [4:0] I_REG_ADDR,
    input wire [7:0] I_REG_WDATA,
    input wire I_STATUS_READ_STOP,
    input wire [7:0] O_REG_RDATA,
    input wire I_TIME_TICK,
    input wire [7:0] I_SECONDS,
    input wire I_FIRST_ALARM_FUNCTION_ON,
    input wire I_SECOND_ALARM_FUNCTION_ON,
    input wire I_ALARM_FLAG_AUTO_CLEAR,
    input wire O_FIRST_ALARM_FLAG,
    input wire O_SECOND_ALARM_FLAG,
    input wire O_IRQ_OUT,
    input wire O_IRQ_OE_N
);
    default clocking cb @(posedge I_SYS_CLK); endclocking
    default disable iff (I_RESET);
    // Status byte write
    wire st_wr = I_REG_WR && I_REG_ADDR == 5'h07;
    a_first_set_tick: assert property ($rose(O_FIRST_ALARM_FLAG) |->
        $past(I_TIME_TICK) && $past(I_FIRST_ALARM_FUNCTION_ON)) else $error("first set no tick");
    a_second_set_zero: assert property ($rose(O_SECOND_ALARM_FLAG) |->
        $past(I_TIME_TICK) && $past(I_SECOND_ALARM_FUNCTION_ON)
        && ($past(I_SECONDS) & 8'h7f) == 8'h00) else $error("second set off time");
    a_auto_wipe: assert property (I_STATUS_READ_STOP && I_ALARM_FLAG_AUTO_CLEAR
        && !I_TIME_TICK |=> !O_FIRST_ALARM_FLAG && !O_SECOND_ALARM_FLAG) else $error("no wipe");
    a_first_sticky: assert property (O_FIRST_ALARM_FLAG && !I_STATUS_READ_STOP
        && !st_wr |=> O_FIRST_ALARM_FLAG) else $error("first flag lost");
    a_wr_clear: assert property (st_wr && !I_REG_WDATA[1] && !I_TIME_TICK
        |=> !O_SECOND_ALARM_FLAG) else $error("second not cleared");
    a_pin_flag: assert property (!O_IRQ_OE_N |-> O_FIRST_ALARM_FLAG)
        else $error("pin low without flag");
    a_pin_data: assert property (O_IRQ_OUT == 1'b0) else $error("pin data high");
    a_status_read: assert property ($past(I_REG_ADDR) == 5'h07 |-> O_REG_RDATA ==
        {5'h00, $past(O_FIRST_ALARM_FLAG), $past(O_SECOND_ALARM_FLAG), 1'b0}) else $error("status");
    a_unmapped_zero: assert property ($past(I_REG_ADDR) > 5'h14 |->
        O_REG_RDATA == 8'h00) else $error("unmapped read");
endmodule // rtcac_alarm_asserts
`default_nettype wire

// ===== rtcac_time_src.sv
// Model of the clock counters feeding the alarm block.
// Assumes the bench calls step once per time update.
`timescale 1ns/1ps
`default_nettype none
module rtcac_time_src (
    // Clock
    input wire i_clk,
    // Time bytes and update tick
    output reg o_tick,
    output reg [47:0] o_time
);
    initial begin
        o_tick = 1'b0;
        o_time = 48'h0;
    end
    task step(input [47:0] t);
        begin
            @(posedge i_clk);
            o_tick <= 1'b1;
            o_time <= t;
            @(posedge i_clk);
            o_tick <= 1'b0;
        end
    endtask
endmodule // rtcac_time_src
`default_nettype wire

// ===== test_rtcac_alarm.sv
// Testbench for the dual alarm compare block.
// Assumes byte strobes as the register port and the counter model as time source.
`timescale 1ns/1ps
`default_nettype none
module test_rtcac_alarm;
    reg clk = 0, rst = 1, wr = 0, stp = 0, fn1 = 0, fn2 = 0, rte = 0, sel = 0, aut = 0;
    reg [4:0] addr = 0;
    reg [7:0] wd = 0;
    wire [7:0] rdata;
    wire [47:0] tm;
    wire tick, f1, f2, irq, oen;
    integer err_total = 0, compares = 0, i, j;
    reg [47:0] t;
    rtcac_time_src src_u (.i_clk(clk), .o_tick(tick), .o_time(tm));
    rtcac_alarm dut_u (.I_SYS_CLK(clk), .I_RESET(rst), .I_REG_WR(wr), .I_REG_ADDR(addr),
        .I_REG_WDATA(wd), .I_STATUS_READ_STOP(stp), .O_REG_RDATA(rdata), .I_TIME_TICK(tick),
        .I_SECONDS(tm[47:40]), .I_MINUTES(tm[39:32]), .I_HOURS(tm[31:24]),
        .I_DATE(tm[23:16]), .I_MONTH(tm[15:8]), .I_WEEKDAY_COUNT(tm[7:0]),
        .I_FIRST_ALARM_FUNCTION_ON(fn1), .I_SECOND_ALARM_FUNCTION_ON(fn2),
        .I_FIRST_ALARM_PIN_ROUTE(rte), .I_OUTPUT_PIN_FUNCTION_SELECT(sel),
        .I_ALARM_FLAG_AUTO_CLEAR(aut), .O_FIRST_ALARM_FLAG(f1), .O_SECOND_ALARM_FLAG(f2),
        .O_IRQ_OUT(irq), .O_IRQ_OE_N(oen));
    // Clock
    always #50 clk = ~clk;
    task check8(input [7:0] g, input [7:0] e);
        begin
            compares = compares + 1;
            if (g !== e) begin
                err_total = err_total + 1;
                $display("BAD %0t got %h exp %h", $time, g, e);
            end
        end
    endtask
    task chk(input e1, input e2, input eo);
        check8({4'h0, irq, f1, f2, oen}, {4'h0, 1'b0, e1, e2, eo});
    endtask
    task wrb(input [4:0] a, input [7:0] d);
        begin
            @(posedge clk);
            wr <= 1;
            addr <= a;
            wd <= d;
            @(posedge clk);
            wr <= 0;
        end
    endtask
    task rdb(input [4:0] a, input [7:0] e);
        begin
            @(posedge clk);
            addr <= a;
            @(posedge clk);
            #1 check8(rdata, e);
        end
    endtask
    task tk(input [47:0] v, input e1, input e2, input eo);
        begin
            src_u.step(v);
            #1 chk(e1, e2, eo);
        end
    endtask
    task stop_rd(input a);
        begin
            @(posedge clk);
            aut <= a;
            stp <= 1;
            @(posedge clk);
            stp <= 0;
            #1;
        end
    endtask
    task print_verdict;
        begin
            $display("Counts: %0d compares, %0d mismatches", compares, err_total);
            if (err_total == 0 && compares > 0)
                $display("== PASSED ==");
            else
                $display("== FAILED ==");
            $finish;
        end
    endtask
    // Hang guard
    initial begin
        #1000000;
        err_total = err_total + 1;
        print_verdict;
    end
    // Main sequence
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        for (i = 0; i < 9; i = i + 1) rdb(5'h0c + i, 8'h00);
        rdb(5'h07, 8'h00);
        rdb(5'h15, 8'h00);
        wrb(5'h0d, 8'hb0);
        rdb(5'h0d, 8'hb0);
        wrb(5'h0d, 8'h00);
        $display("test reset done");
        fn1 <= 1;
        rte <= 1;
        sel <= 1;
        tk({6{8'h01}}, 1, 0, 0);
        rdb(5'h07, 8'h04);
        @(posedge clk);
        rte <= 0;
        repeat (2) @(posedge clk);
        #1 chk(1, 0, 1);
        @(posedge clk);
        rte <= 1;
        wrb(5'h07, 8'h06);
        #1 chk(1, 0, 0);
        wrb(5'h07, 8'h00);
        repeat (3) @(posedge clk);
        #1 chk(0, 0, 1);
        $display("test every second done");
        for (i = 0; i < 6; i = i + 1) begin
            wrb(5'h0c + i, 8'h85);
            for (j = 0; j < 6; j = j + 1) t[8*(5-j) +: 8] = (j == i) ? 8'h06 : 8'h05;
            tk(t, 0, 0, 1);
            tk(t ^ {6{8'h03}}, 1, 0, 0);
            wrb(5'h07, 8'h00);
            wrb(5'h0c + i, 8'h00);
        end
        $display("test field map done");
        t = 48'h00b091818100;
        for (i = 0; i < 6; i = i + 1) wrb(5'h0c + i, t[8*(5-i) +: 8]);
        tk(48'h592911010103, 0, 0, 1);
        tk(48'h003011010103, 1, 0, 0);
        wrb(5'h07, 8'h00);
        tk(48'h003051010103, 0, 0, 1);
        $display("test alarm1 example done");
        @(posedge clk);
        fn1 <= 0;
        fn2 <= 1;
        tk(48'h010000000000, 0, 0, 1);
        tk(48'h000000000000, 0, 1, 1);
        stop_rd(0);
        chk(0, 1, 1);
        stop_rd(1);
        chk(0, 0, 1);
        wrb(5'h13, 8'he0);
        wrb(5'h14, 8'hc1);
        tk(48'h000060050101, 0, 1, 1);
        wrb(5'h07, 8'h00);
        #1 chk(0, 0, 1);
        tk(48'h000060010102, 0, 0, 1);
        wrb(5'h14, 8'h81);
        tk(48'h000060010102, 0, 1, 1);
        wrb(5'h07, 8'h00);
        wrb(5'h12, 8'h85);
        tk(48'h000660010102, 0, 0, 1);
        tk(48'h000560010102, 0, 1, 1);
        $display("test alarm2 done");
        print_verdict;
    end
endmodule // test_rtcac_alarm
bind rtcac_alarm rtcac_alarm_asserts chk_u (.I_SYS_CLK(I_SYS_CLK), .I_RESET(I_RESET),
    .I_REG_WR(I_REG_WR), .I_REG_ADDR(I_REG_ADDR), .I_REG_WDATA(I_REG_WDATA),
    .I_STATUS_READ_STOP(I_STATUS_READ_STOP), .O_REG_RDATA(O_REG_RDATA),
    .I_TIME_TICK(I_TIME_TICK), .I_SECONDS(I_SECONDS),
    .I_FIRST_ALARM_FUNCTION_ON(I_FIRST_ALARM_FUNCTION_ON),
    .I_SECOND_ALARM_FUNCTION_ON(I_SECOND_ALARM_FUNCTION_ON),
    .I_ALARM_FLAG_AUTO_CLEAR(I_ALARM_FLAG_AUTO_CLEAR), .O_FIRST_ALARM_FLAG(O_FIRST_ALARM_FLAG),
    .O_SECOND_ALARM_FLAG(O_SECOND_ALARM_FLAG), .O_IRQ_OUT(O_IRQ_OUT), .O_IRQ_OE_N(O_IRQ_OE_N));
`default_nettype wire
